// ===== msc_pkg.sv
// Package for the mode-setting configuration registers.
// Assumes an I2C target elsewhere turns bus frames into byte writes and reads.
package msc_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_M2_P2 = 8'h2c;  // Enables and always-on voltage
  localparam logic [7:0] ADDR_M2_P3 = 8'h2d;  // Watchdog and system regulator
  localparam logic [7:0] ADDR_M3_P0 = 8'h2e;  // Ship, source select, core buck
  // Reset values
  localparam logic [7:0] RST_M2_P2  = 8'h4f;
  localparam logic [7:0] RST_M2_P3  = 8'h0c;
  localparam logic [7:0] RST_M3_P0  = 8'h1c;
  // Field positions
  localparam int AON_CODE_LSB  = 4;
  localparam int CORE_ON_BIT   = 3;
  localparam int SBUCK_ON_BIT  = 2;
  localparam int AON_ON_BIT    = 1;
  localparam int SREG_ON_BIT   = 0;
  localparam int WD_LSB        = 6;
  localparam int SREG_OFS_BIT  = 5;
  localparam int SHIP_BIT      = 7;
  localparam int SRC_PINS_BIT  = 6;
  // Mode settings
  localparam logic [1:0] MODE_2 = 2'h2;
  localparam logic [1:0] MODE_3 = 2'h3;
  // Voltage scale in millivolts
  localparam logic [11:0] MV_STEP      = 12'h019;  // 25 mV
  localparam logic [11:0] MV_AON_BASE  = 12'h6a4;  // 1700 mV
  localparam logic [11:0] MV_AON_MAX   = 12'h76c;  // 1900 mV
  localparam logic [3:0]  AON_TOP_CODE = 4'h8;
  localparam logic [11:0] MV_SYS_BASE  = 12'h5dc;  // 1500 mV
  localparam logic [4:0]  SYS_TOP_CODE = 5'h18;    // 2100 mV
  localparam logic [11:0] MV_OFFSET    = 12'h4b0;  // 1200 mV
  localparam logic [11:0] MV_CORE_BASE = 12'h1f4;  // 500 mV
  localparam logic [5:0]  CORE_TOP     = 6'h28;    // 1500 mV
  localparam logic [11:0] MV_CORE_MAX  = 12'h5dc;  // 1500 mV
  localparam logic [11:0] MV_CORE_FIX  = 12'h708;  // 1800 mV
  // Watchdog base period in seconds
  localparam int WD_BASE_S = 16;
endpackage : msc_pkg

// ===== msc_volt_decode.sv
// Code to millivolt decoders for the regulator voltage fields.
// Assumes codes are stable register outputs; purely combinational.
`timescale 1ns/100ps
module msc_volt_decode (
  input  wire logic [3:0]  aon_code,
  input  wire logic [4:0]  sreg_code,
  input  wire logic        sreg_ofs,
  input  wire logic [4:0]  sbuck_code,
  input  wire logic        sbuck_ofs,
  input  wire logic [5:0]  core_code,
  output logic      [11:0] aon_mv,
  output logic      [11:0] sreg_mv,
  output logic      [11:0] sbuck_mv,
  output logic      [11:0] core_mv
);
  // Saturating 25 mV ladder from 1.5 V, plus optional 1.2 V offset
  function automatic logic [11:0] sys_mv(input logic [4:0] c, input logic ofs);
    logic [4:0] cc;
    cc = (c > msc_pkg::SYS_TOP_CODE) ? msc_pkg::SYS_TOP_CODE : c;
    return 12'(msc_pkg::MV_SYS_BASE + 12'(cc) * msc_pkg::MV_STEP
               + (ofs ? msc_pkg::MV_OFFSET : 12'h000));
  endfunction : sys_mv

  // Decoders
  always_comb begin
    aon_mv = (aon_code > msc_pkg::AON_TOP_CODE) ? msc_pkg::MV_AON_MAX
           : 12'(msc_pkg::MV_AON_BASE + 12'(aon_code) * msc_pkg::MV_STEP);
    sreg_mv  = sys_mv(sreg_code, sreg_ofs);
    sbuck_mv = sys_mv(sbuck_code, sbuck_ofs);
    if (core_code == 6'h3f) begin
      core_mv = msc_pkg::MV_CORE_FIX;
    end else if (core_code > msc_pkg::CORE_TOP) begin
      core_mv = msc_pkg::MV_CORE_MAX;
    end else begin
      core_mv = 12'(msc_pkg::MV_CORE_BASE + 12'(core_code) * msc_pkg::MV_STEP);
    end
  end
endmodule : msc_volt_decode

// ===== msc_mode_regs.sv
// Mode setting 2 (parts 2, 3) and mode setting 3 (part 0) configuration registers.
// Assumes a byte register port from the I2C target and synchronous inputs.
//
// Summary of operation
// - Bits 7:4 code always-on voltage, saturating 1.9 V
// - Bits 3:0 enable four regulators, reset on
// - Watchdog field: off, 16, 32, 64 seconds
// - Offset bit adds 1.2 V to system regulator
// - System regulator code, 25 mV from 1.5 V
// - System buck code, 25 mV, capped 2.1 V
// - Ship bit enters ship mode in setting 3
// - Source bit picks pins or register bits
// - Core buck code 0.5-1.5 V, top 1.8 V
// - All three registers read and write back
// - System buck offset bit adds 1.2 V
`timescale 1ns/100ps
module msc_mode_regs #(
  parameter int TICKS_PER_S = 10_000_000  // Clock cycles per second
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        mode_pin_a,
  input  wire logic        mode_pin_b,
  input  wire logic        mode_reg_bit_a,
  input  wire logic        mode_reg_bit_b,
  input  wire logic [4:0]  system_buck_code_m2,
  input  wire logic        system_buck_offset_m2,
  input  wire logic        wd_kick,
  output logic      [1:0]  active_mode,
  output logic             core_buck_on,
  output logic             system_buck_on,
  output logic             aon_reg_on,
  output logic             system_reg_on,
  output logic      [11:0] aon_reg_mv,
  output logic      [11:0] system_reg_mv,
  output logic      [11:0] system_buck_mv,
  output logic      [11:0] core_buck_mv,
  output logic             ship_mode,
  output logic             wd_expire
);
  // Largest period is 64 s; the counter must hold it
  localparam longint WD_MAX = longint'(TICKS_PER_S) * msc_pkg::WD_BASE_S * 4;
  // Refuse tick counts the 32-bit counter cannot serve
  if (TICKS_PER_S < 1 || WD_MAX >= 64'h0000_0000_ffff_ffff) begin : g_bad_ticks
    $error("TICKS_PER_S out of range");
  end

  // Register file state
  logic [7:0]  m2p2_r, m2p2_nxt;        // Enables and always-on code
  logic [7:0]  m2p3_r, m2p3_nxt;        // Watchdog and system regulator
  logic [7:0]  m3p0_r, m3p0_nxt;        // Ship, source, core buck
  logic [7:0]  rdata_r, rdata_nxt;      // Read data holding register
  logic [1:0]  mode_r, mode_nxt;        // Active mode setting
  // Output state
  logic [3:0]  en_r, en_nxt;            // Gated regulator enables
  logic [11:0] aon_r, aon_nxt;
  logic [11:0] sreg_r, sreg_nxt;
  logic [11:0] sbuck_r, sbuck_nxt;
  logic [11:0] core_r, core_nxt;
  logic        ship_r, ship_nxt;
  // Watchdog state
  logic [31:0] wd_cnt_r, wd_cnt_nxt;    // Cycles since last kick or expiry
  logic        wd_exp_r, wd_exp_nxt;    // Expiry pulse
  logic [31:0] wd_limit;                // Cycles in chosen period
  logic        wd_run;                  // Watchdog counting
  // Decoded field names
  logic [1:0]  watchdog_period_m2;
  logic        mode_source_is_pins_m3;
  logic [11:0] dec_aon, dec_sreg, dec_sbuck, dec_core;

  assign watchdog_period_m2     = m2p3_r[msc_pkg::WD_LSB +: 2];
  assign mode_source_is_pins_m3 = m3p0_r[msc_pkg::SRC_PINS_BIT];

  // Voltage decoders
  msc_volt_decode u_dec (
    .aon_code   (m2p2_r[msc_pkg::AON_CODE_LSB +: 4]),
    .sreg_code  (m2p3_r[4:0]),
    .sreg_ofs   (m2p3_r[msc_pkg::SREG_OFS_BIT]),
    .sbuck_code (system_buck_code_m2),
    .sbuck_ofs  (system_buck_offset_m2),
    .core_code  (m3p0_r[5:0]),
    .aon_mv     (dec_aon),
    .sreg_mv    (dec_sreg),
    .sbuck_mv   (dec_sbuck),
    .core_mv    (dec_core)
  );

  // Register writes, reads and mode selection
  always_comb begin
    m2p2_nxt  = m2p2_r;
    m2p3_nxt  = m2p3_r;
    m3p0_nxt  = m3p0_r;
    rdata_nxt = rdata_r;
    if (reg_wr) begin
      case (reg_addr)
        msc_pkg::ADDR_M2_P2: m2p2_nxt = reg_wdata;
        msc_pkg::ADDR_M2_P3: m2p3_nxt = reg_wdata;
        msc_pkg::ADDR_M3_P0: m3p0_nxt = reg_wdata;
        default: ;                                 // Unmapped write ignored
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        msc_pkg::ADDR_M2_P2: rdata_nxt = m2p2_r;
        msc_pkg::ADDR_M2_P3: rdata_nxt = m2p3_r;
        msc_pkg::ADDR_M3_P0: rdata_nxt = m3p0_r;
        default:             rdata_nxt = 8'h00;    // Unmapped reads zero
      endcase
    end
    // Pins or register bits, never a mix
    if (mode_source_is_pins_m3) begin
      mode_nxt = {mode_pin_b, mode_pin_a};
    end else begin
      mode_nxt = {mode_reg_bit_b, mode_reg_bit_a};
    end
  end

  // Mode-gated controls
  always_comb begin
    en_nxt    = 4'h0;
    aon_nxt   = 12'h000;
    sreg_nxt  = 12'h000;
    sbuck_nxt = 12'h000;
    core_nxt  = 12'h000;
    ship_nxt  = 1'b0;
    if (mode_r == msc_pkg::MODE_2) begin
      en_nxt    = m2p2_r[3:0];
      aon_nxt   = dec_aon;
      sreg_nxt  = dec_sreg;
      sbuck_nxt = dec_sbuck;
    end
    if (mode_r == msc_pkg::MODE_3) begin
      core_nxt  = dec_core;
      ship_nxt  = m3p0_r[msc_pkg::SHIP_BIT];
    end
  end

  // Watchdog period and counter
  always_comb begin
    wd_limit   = 32'(TICKS_PER_S * msc_pkg::WD_BASE_S) << (watchdog_period_m2 - 2'h1);
    wd_run     = (mode_r == msc_pkg::MODE_2) && (watchdog_period_m2 != 2'h0);
    wd_exp_nxt = 1'b0;
    wd_cnt_nxt = wd_cnt_r;
    if (!wd_run || wd_kick) begin
      wd_cnt_nxt = 32'h0000_0000;
    end else if (wd_cnt_r >= wd_limit - 32'h0000_0001) begin
      wd_cnt_nxt = 32'h0000_0000;
      wd_exp_nxt = 1'b1;
    end else begin
      wd_cnt_nxt = wd_cnt_r + 32'h0000_0001;
    end
  end

  // Register file and mode state
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      m2p2_r   <= msc_pkg::RST_M2_P2;
      m2p3_r   <= msc_pkg::RST_M2_P3;
      m3p0_r   <= msc_pkg::RST_M3_P0;
      rdata_r  <= 8'h00;
      mode_r   <= 2'h0;
    end else begin
      m2p2_r   <= m2p2_nxt;
      m2p3_r   <= m2p3_nxt;
      m3p0_r   <= m3p0_nxt;
      rdata_r  <= rdata_nxt;
      mode_r   <= mode_nxt;
    end
  end

  // Gated control outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      en_r     <= 4'h0;
      aon_r    <= 12'h000;
      sreg_r   <= 12'h000;
      sbuck_r  <= 12'h000;
      core_r   <= 12'h000;
      ship_r   <= 1'b0;
    end else begin
      en_r     <= en_nxt;
      aon_r    <= aon_nxt;
      sreg_r   <= sreg_nxt;
      sbuck_r  <= sbuck_nxt;
      core_r   <= core_nxt;
      ship_r   <= ship_nxt;
    end
  end

  // Watchdog counter and expiry pulse
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wd_cnt_r <= 32'h0000_0000;
      wd_exp_r <= 1'b0;
    end else begin
      wd_cnt_r <= wd_cnt_nxt;
      wd_exp_r <= wd_exp_nxt;
    end
  end

  // Outputs
  assign reg_rdata      = rdata_r;
  assign active_mode    = mode_r;
  assign core_buck_on   = en_r[msc_pkg::CORE_ON_BIT];
  assign system_buck_on = en_r[msc_pkg::SBUCK_ON_BIT];
  assign aon_reg_on     = en_r[msc_pkg::AON_ON_BIT];
  assign system_reg_on  = en_r[msc_pkg::SREG_ON_BIT];
  assign aon_reg_mv     = aon_r;
  assign system_reg_mv  = sreg_r;
  assign system_buck_mv = sbuck_r;
  assign core_buck_mv   = core_r;
  assign ship_mode      = ship_r;
  assign wd_expire      = wd_exp_r;

  // Checks
  AST_WRITE_M2P3: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_wr && reg_addr == msc_pkg::ADDR_M2_P3 |=> m2p3_r == $past(reg_wdata))
    else $error("Write to watchdog register lost");
  AST_READ_M3P0: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_rd && reg_addr == msc_pkg::ADDR_M3_P0 |=> reg_rdata == $past(m3p0_r))
    else $error("Read of ship register wrong");
  AST_AON_SAT: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode_r == 2'h2 && m2p2_r[7:4] > 4'h8 |=> aon_reg_mv == 12'd1900)
    else $error("Always-on voltage not capped at 1900 mV");
  AST_EN_GATED: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode_r == 2'h2 |=> {core_buck_on, system_buck_on, aon_reg_on, system_reg_on}
                       == $past(m2p2_r[3:0]))
    else $error("Mode 2 enables not passed");
  AST_SREG_OFS: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode_r == 2'h2 && m2p3_r[5] && m2p3_r[4:0] == 5'h00 |=> system_reg_mv == 12'd2700)
    else $error("Offset not added to system regulator");
  AST_SREG_TOP: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode_r == 2'h2 && m2p3_r[5:0] == 6'h1f |=> system_reg_mv == 12'd2100)
    else $error("System regulator code not capped");
  AST_SBUCK: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode_r == 2'h2 && !system_buck_offset_m2 && system_buck_code_m2 == 5'h0c
    |=> system_buck_mv == 12'd1800)
    else $error("System buck default not 1800 mV");
  AST_SBUCK_OFS: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode_r == 2'h2 && system_buck_offset_m2 && system_buck_code_m2 == 5'h18
    |=> system_buck_mv == 12'd3300)
    else $error("System buck offset wrong");
  AST_SHIP: assert property (@(posedge ref_clk) disable iff (!nrst)
    ship_mode |-> $past(mode_r) == 2'h3 && $past(m3p0_r[7]))
    else $error("Ship mode outside mode 3");
  AST_SOURCE: assert property (@(posedge ref_clk) disable iff (!nrst)
    m3p0_r[6] |=> active_mode == $past({mode_pin_b, mode_pin_a}))
    else $error("Pins not used as mode source");
  AST_CORE: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode_r == 2'h3 && m3p0_r[5:0] == 6'h3f |=> core_buck_mv == 12'd1800)
    else $error("Core buck top code not 1800 mV");
  AST_GATE: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode_r != 2'h2 |=> !core_buck_on && aon_reg_mv == 12'h000 && !wd_expire)
    else $error("Mode 2 fields leak outside mode 2");
  AST_WD_OFF: assert property (@(posedge ref_clk) disable iff (!nrst)
    m2p3_r[7:6] == 2'h0 |=> wd_cnt_r == 32'h0 && !wd_expire)
    else $error("Disabled watchdog counting");
endmodule : msc_mode_regs

// ===== mode_setting_config_regs_tb.sv
// Self-checking bench for the mode-setting configuration registers.
// Assumes msc_mode_regs with its byte register port and TICKS_PER_S set to 2.
`timescale 1ns/100ps
module mode_setting_config_regs_tb;
  logic        ref_clk, nrst, reg_wr, reg_rd, wd_kick;  // Clock, reset, strobes
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;          // Register port
  logic        mode_pin_a, mode_pin_b;                  // External select pins
  logic        mode_reg_bit_a, mode_reg_bit_b;          // Register select bits
  logic [4:0]  system_buck_code_m2;                     // Buck code from 0x2b
  logic        system_buck_offset_m2;                   // Buck offset from 0x2b
  logic [1:0]  active_mode;                             // Selected mode
  logic        core_buck_on, system_buck_on, aon_reg_on, system_reg_on;
  logic [11:0] aon_reg_mv, system_reg_mv, system_buck_mv, core_buck_mv;
  logic        ship_mode, wd_expire;                    // Ship and watchdog
  int          err_count, n_checks;                     // Tallies
  logic [11:0] cnt;                                     // Watchdog interval
  logic [7:0]  v;                                       // Written byte

  msc_mode_regs #(.TICKS_PER_S(2)) uut (.ref_clk(ref_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mode_pin_a(mode_pin_a), .mode_pin_b(mode_pin_b),
    .mode_reg_bit_a(mode_reg_bit_a), .mode_reg_bit_b(mode_reg_bit_b),
    .system_buck_code_m2(system_buck_code_m2),
    .system_buck_offset_m2(system_buck_offset_m2), .wd_kick(wd_kick),
    .active_mode(active_mode), .core_buck_on(core_buck_on),
    .system_buck_on(system_buck_on), .aon_reg_on(aon_reg_on),
    .system_reg_on(system_reg_on), .aon_reg_mv(aon_reg_mv),
    .system_reg_mv(system_reg_mv), .system_buck_mv(system_buck_mv),
    .core_buck_mv(core_buck_mv), .ship_mode(ship_mode), .wd_expire(wd_expire));

  // 100 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // One edge, then the fixed drive delay
  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask : step

  // Compare a register byte
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  // Compare a millivolt or count value
  task automatic chk_mv(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_mv

  // Compare a control bit
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  // Byte write, strobe one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    step();
    reg_wr    = 1'b0;
    step();
  endtask : wr

  // Byte read, data checked the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd   = 1'b1;
    step();
    reg_rd   = 1'b0;
    chk_byte(reg_rdata, exp);
    step();
  endtask : rd_chk

  // Let active mode and gated outputs settle
  task automatic settle;
    repeat (3) step();
  endtask : settle

  // Select mode through the register bits
  task automatic set_mode(input logic [1:0] m);
    mode_reg_bit_b = m[1];
    mode_reg_bit_a = m[0];
    settle();
  endtask : set_mode

  // Print counts and verdict, then stop
  task automatic results;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // Hang guard, far beyond the expected run
  initial begin
    #5_000_000;
    err_count++;
    results();
  end

  // Main sequence
  initial begin
    {nrst, reg_wr, reg_rd, wd_kick, mode_pin_a, mode_pin_b} = '0;
    {mode_reg_bit_a, mode_reg_bit_b, system_buck_offset_m2} = '0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    system_buck_code_m2 = 5'h0c;
    err_count = 0;
    n_checks = 0;
    repeat (5) step();
    nrst = 1'b1;
    step();
    // Defaults and unmapped places
    rd_chk(8'h2c, 8'h4f);
    rd_chk(8'h2d, 8'h0c);
    rd_chk(8'h2e, 8'h1c);
    rd_chk(8'h2b, 8'h00);
    rd_chk(8'h2f, 8'h00);
    settle();
    chk_bit(core_buck_on, 1'b0);
    set_mode(2'h2);
    chk_byte({6'h00, active_mode}, 8'h02);
    chk_mv(system_buck_mv, 12'h708);
    // Always-on codes and enable bits
    for (int c = 0; c < 16; c++) begin
      v = {c[3:0], c[3:0]};
      wr(8'h2c, v);
      rd_chk(8'h2c, v);
      settle();
      chk_bit(core_buck_on, v[3]);
      chk_bit(system_buck_on, v[2]);
      chk_bit(aon_reg_on, v[1]);
      chk_bit(system_reg_on, v[0]);
      chk_mv(aon_reg_mv, 12'(1700 + 25 * (c > 8 ? 8 : c)));
    end
    // System regulator and buck ladders with offsets
    for (int c = 0; c < 64; c++) begin
      v = {2'b00, c[5:0]};
      system_buck_code_m2 = c[4:0];
      system_buck_offset_m2 = ~c[5];
      wr(8'h2d, v);
      rd_chk(8'h2d, v);
      settle();
      chk_mv(system_reg_mv, 12'(1500 + 25 * (c[4:0] > 24 ? 24 : c[4:0])
                               + (c[5] ? 1200 : 0)));
      chk_mv(system_buck_mv, 12'(1500 + 25 * (c[4:0] > 24 ? 24 : c[4:0])
                                + (c[5] ? 0 : 1200)));
    end
    // Watchdog periods, interval between pulses
    for (int p = 1; p < 4; p++) begin
      wr(8'h2d, {p[1:0], 6'h0c});
      for (int i = 0; i < 300 && wd_expire !== 1'b1; i++) step();
      chk_bit(wd_expire, 1'b1);
      step();
      cnt = 12'h001;
      while (wd_expire !== 1'b1 && cnt < 12'h200) begin
        step();
        cnt++;
      end
      chk_mv(cnt, 12'(32 << (p - 1)));
    end
    // Kick held, then period off: no pulse
    wd_kick = 1'b1;
    v = 8'h00;
    repeat (200) begin step(); v[0] = v[0] | wd_expire; end
    wd_kick = 1'b0;
    wr(8'h2d, 8'h0c);
    repeat (200) begin step(); v[0] = v[0] | wd_expire; end
    chk_bit(v[0], 1'b0);
    chk_bit(ship_mode, 1'b0);
    chk_mv(core_buck_mv, 12'h000);
    // Mode 3 core ladder with ship bit
    set_mode(2'h3);
    chk_mv(aon_reg_mv, 12'h000);
    chk_bit(system_reg_on, 1'b0);
    for (int c = 0; c < 64; c++) begin
      v = {c[0], 1'b0, c[5:0]};
      wr(8'h2e, v);
      rd_chk(8'h2e, v);
      settle();
      chk_bit(ship_mode, c[0]);
      chk_mv(core_buck_mv, 12'(c == 63 ? 1800 : 500 + 25 * (c > 40 ? 40 : c)));
    end
    // Pins take over as mode source
    mode_pin_b = 1'b1;
    mode_pin_a = 1'b0;
    wr(8'h2e, 8'h5c);
    settle();
    chk_byte({6'h00, active_mode}, 8'h02);
    chk_bit(ship_mode, 1'b0);
    chk_mv(core_buck_mv, 12'h000);
    mode_pin_b = 1'b0;
    mode_pin_a = 1'b1;
    settle();
    chk_byte({6'h00, active_mode}, 8'h01);
    chk_mv(system_reg_mv, 12'h000);
    chk_mv(system_buck_mv, 12'h000);
    chk_bit(system_buck_on, 1'b0);
    // Back to register bits, then a reset in mid-run
    wr(8'h2e, 8'h9c);
    settle();
    chk_byte({6'h00, active_mode}, 8'h03);
    chk_bit(ship_mode, 1'b1);
    nrst = 1'b0;
    step();
    nrst = 1'b1;
    step();
    rd_chk(8'h2c, 8'h4f);
    rd_chk(8'h2d, 8'h0c);
    rd_chk(8'h2e, 8'h1c);
    settle();
    chk_bit(ship_mode, 1'b0);
    chk_mv(core_buck_mv, 12'd1200);
    results();
  end
endmodule : mode_setting_config_regs_tb
